/* File: design/aoc_map.vh */
// aoc_map.vh: register indices, reset values, field positions and constants
// for the attenuator and overload control block.
// assumes: included by the block's single design file, word-aligned registers.
`ifndef AOC_MAP_VH
`define AOC_MAP_VH

// register indices, byte address is four times the index
`define AOC_IDX_MODE 10'h180
`define AOC_IDX_LVL_LO 10'h181
`define AOC_IDX_LVL_HI 10'h182
`define AOC_IDX_START 10'h183
`define AOC_IDX_STATUS 10'h184
`define AOC_IDX_THRESH 10'h188
`define AOC_IDX_PLEN 10'h189
`define AOC_IDX_BACKOFF 10'h18A
`define AOC_IDX_IRQ_STAT 10'h18C
`define AOC_IDX_IRQ_MASK 10'h18D
`define AOC_IDX_UNSTABLE 10'h18F

// reset values
`define AOC_RST_MODE 8'h00
`define AOC_RST_LVL 8'h0C
`define AOC_RST_START 8'h00
`define AOC_RST_CODE 5'h0C
`define AOC_RST_THRESH 8'h05
`define AOC_RST_PLEN 8'h01
`define AOC_RST_BACKOFF 8'h06
`define AOC_RST_IRQ 2'h0

// field positions
`define AOC_MODE_BIT 0
`define AOC_PIN_BIT 7
`define AOC_RSV_HI 6
`define AOC_RSV_LO 5
`define AOC_CODE_HI 4
`define AOC_THR_HI 2
`define AOC_PLEN_HI 4
`define AOC_STEP_HI 4
`define AOC_FLAG_BIT 0
`define AOC_CLR_BIT 1
`define AOC_IRQ_OVL 0
`define AOC_IRQ_STEP 1
`define AOC_IRQ_HI 1

// code range and detector constants
`define AOC_MAX_CODE 5'h1B
`define AOC_ONE_CODE 5'h01
`define AOC_ZERO_CODE 5'h00
`define AOC_FS_POS 5'h08
`define AOC_FS_NEG 5'h18
`define AOC_GRP_LAST 3'h7
`define AOC_PULSE_LSBS 3'h7
`define AOC_CNT_ZERO 8'h00

// bus constants
`define AOC_HTRANS_NONSEQ_BIT 1
`define AOC_HRESP_OKAY 1'b0
`define AOC_DATA_ZERO 32'h00000000

`endif

/* File: design/aoc_top.v */
// aoc_top.v: attenuator control with converter overload protection,
// AHB-Lite register slave and a level interrupt.
// assumes: gain pins are asynchronous; converter samples arrive on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_map.vh"

module aoc_top
(
  // clock and reset
  input wire mclk,
  input wire nrst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_q,
  output reg hreadyout_q,
  output reg hresp_q,
  // gain control pins
  input wire gain_down_pin,
  input wire gain_select_up_pin,
  // converter samples, mclk domain
  input wire sample_valid,
  input wire [4:0] sample_data,
  // attenuator and converter controls
  output reg [4:0] atten_code_q,
  output reg atten_enable_q,
  output reg converter_reset_q,
  // interrupt
  output reg irq_q
);

  function [4:0] aoc_sat_add;
    input [4:0] a;
    input [4:0] b;
    reg [5:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s > {1'b0, `AOC_MAX_CODE})
        aoc_sat_add = `AOC_MAX_CODE;
      else
        aoc_sat_add = s[4:0];
    end
  endfunction

  function [4:0] aoc_sat_dec;
    input [4:0] a;
    begin
      if (a > `AOC_MAX_CODE)
        aoc_sat_dec = `AOC_MAX_CODE;
      else if (a == `AOC_ZERO_CODE)
        aoc_sat_dec = `AOC_ZERO_CODE;
      else
        aoc_sat_dec = a - `AOC_ONE_CODE;
    end
  endfunction

  // register file
  reg [7:0] mode_q;
  reg [7:0] lvl_lo_q;
  reg [7:0] lvl_hi_q;
  reg [7:0] start_q;
  reg [1:0] status_rsv_q;
  reg [7:0] thresh_q;
  reg [7:0] plen_q;
  reg [7:0] backoff_q;
  reg unstable_q;
  reg [`AOC_IRQ_HI:0] irq_stat_q;
  reg [`AOC_IRQ_HI:0] irq_mask_q;

  // bus state
  reg wr_pend_q;
  reg rd_pend_q;
  reg [9:0] addr_q;

  // pin synchronisers and edge history
  reg down_s1_q;
  reg down_s2_q;
  reg down_s3_q;
  reg up_s1_q;
  reg up_s2_q;
  reg up_s3_q;

  // attenuation state
  reg [4:0] cur_q;
  reg [4:0] cur_d;
  reg [4:0] sel_prev_q;
  reg mode_prev_q;

  // overload detector
  reg [2:0] grp_idx_q;
  reg [3:0] fs_cnt_q;
  reg [7:0] pulse_cnt_q;

  wire addr_phase;
  wire wr_now;
  wire [9:0] wr_idx;
  wire [7:0] wdat;
  wire step_mode;
  wire [4:0] sel_val;
  wire down_edge;
  wire up_edge;
  wire is_fs;
  wire [3:0] fs_total;
  wire ovl_evt;
  wire step_evt;
  reg [31:0] rd_mux;
  reg [`AOC_IRQ_HI:0] irq_stat_d;

  assign addr_phase = hsel & hready & htrans[`AOC_HTRANS_NONSEQ_BIT];
  assign wr_now = wr_pend_q;
  assign wr_idx = addr_q;
  assign wdat = hwdata[7:0];
  assign step_mode = mode_q[`AOC_MODE_BIT];

  // level select from the synchronised pin
  assign sel_val = up_s2_q ? lvl_hi_q[`AOC_CODE_HI:0] : lvl_lo_q[`AOC_CODE_HI:0];
  assign down_edge = down_s2_q & ~down_s3_q;
  assign up_edge = up_s2_q & ~up_s3_q;
  assign step_evt = step_mode & (down_edge | up_edge);

  // full scale is exactly plus or minus eight
  assign is_fs = sample_valid & ((sample_data == `AOC_FS_POS) | (sample_data == `AOC_FS_NEG));
  assign fs_total = fs_cnt_q + {3'h0, is_fs};
  // a group that closes while the pulse runs does not retrigger it
  assign ovl_evt = sample_valid & (grp_idx_q == `AOC_GRP_LAST) &
    (fs_total > {1'b0, thresh_q[`AOC_THR_HI:0]}) & ~converter_reset_q;

  // bus front end: writes take no wait, reads one wait state
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 10'h000;
      hreadyout_q <= 1'b1;
      hresp_q <= `AOC_HRESP_OKAY;
      hrdata_q <= `AOC_DATA_ZERO;
    end
    else
    begin
      hresp_q <= `AOC_HRESP_OKAY;
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase)
        addr_q <= haddr[11:2];
      if (addr_phase & ~hwrite)
      begin
        rd_pend_q <= 1'b1;
        hreadyout_q <= 1'b0;
      end
      else if (rd_pend_q)
      begin
        rd_pend_q <= 1'b0;
        hreadyout_q <= 1'b1;
        hrdata_q <= rd_mux;
      end
    end
  end

  // read decode, unmapped reads as zero
  always @*
  begin
    rd_mux = `AOC_DATA_ZERO;
    if (addr_q == `AOC_IDX_MODE)
      rd_mux[7:0] = mode_q;
    else if (addr_q == `AOC_IDX_LVL_LO)
      rd_mux[7:0] = lvl_lo_q;
    else if (addr_q == `AOC_IDX_LVL_HI)
      rd_mux[7:0] = lvl_hi_q;
    else if (addr_q == `AOC_IDX_START)
      rd_mux[7:0] = start_q;
    else if (addr_q == `AOC_IDX_STATUS)
    begin
      rd_mux[`AOC_PIN_BIT] = up_s2_q;
      rd_mux[`AOC_RSV_HI:`AOC_RSV_LO] = status_rsv_q;
      rd_mux[`AOC_CODE_HI:0] = cur_q;
    end
    else if (addr_q == `AOC_IDX_THRESH)
      rd_mux[7:0] = thresh_q;
    else if (addr_q == `AOC_IDX_PLEN)
      rd_mux[7:0] = plen_q;
    else if (addr_q == `AOC_IDX_BACKOFF)
      rd_mux[7:0] = backoff_q;
    else if (addr_q == `AOC_IDX_IRQ_STAT)
      rd_mux[`AOC_IRQ_HI:0] = irq_stat_q;
    else if (addr_q == `AOC_IDX_IRQ_MASK)
      rd_mux[`AOC_IRQ_HI:0] = irq_mask_q;
    else if (addr_q == `AOC_IDX_UNSTABLE)
      rd_mux[`AOC_FLAG_BIT] = unstable_q;
  end

  // software registers
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= `AOC_RST_MODE;
      lvl_lo_q <= `AOC_RST_LVL;
      lvl_hi_q <= `AOC_RST_LVL;
      start_q <= `AOC_RST_START;
      status_rsv_q <= 2'h0;
      thresh_q <= `AOC_RST_THRESH;
      plen_q <= `AOC_RST_PLEN;
      backoff_q <= `AOC_RST_BACKOFF;
      irq_mask_q <= `AOC_RST_IRQ;
    end
    else if (wr_now)
    begin
      if (wr_idx == `AOC_IDX_MODE)
        mode_q <= wdat;
      else if (wr_idx == `AOC_IDX_LVL_LO)
        lvl_lo_q <= wdat;
      else if (wr_idx == `AOC_IDX_LVL_HI)
        lvl_hi_q <= wdat;
      else if (wr_idx == `AOC_IDX_START)
        start_q <= wdat;
      else if (wr_idx == `AOC_IDX_STATUS)
        status_rsv_q <= wdat[`AOC_RSV_HI:`AOC_RSV_LO];
      else if (wr_idx == `AOC_IDX_THRESH)
        thresh_q <= wdat;
      else if (wr_idx == `AOC_IDX_PLEN)
        plen_q <= wdat;
      else if (wr_idx == `AOC_IDX_BACKOFF)
        backoff_q <= wdat;
      else if (wr_idx == `AOC_IDX_IRQ_MASK)
        irq_mask_q <= wdat[`AOC_IRQ_HI:0];
    end
  end

  // sticky flag: a new event beats a clear in the same cycle
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      unstable_q <= 1'b0;
    else if (ovl_evt)
      unstable_q <= 1'b1;
    else if (wr_now & (wr_idx == `AOC_IDX_UNSTABLE) & wdat[`AOC_CLR_BIT])
      unstable_q <= 1'b0;
  end

  // interrupt status, write one to clear, set wins
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (wr_now & (wr_idx == `AOC_IDX_IRQ_STAT))
      irq_stat_d = irq_stat_q & ~wdat[`AOC_IRQ_HI:0];
    if (ovl_evt)
      irq_stat_d[`AOC_IRQ_OVL] = 1'b1;
    if (step_evt)
      irq_stat_d[`AOC_IRQ_STEP] = 1'b1;
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat_q <= `AOC_RST_IRQ;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // two-flop pin synchronisers, third stage only for edges
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      down_s1_q <= 1'b0;
      down_s2_q <= 1'b0;
      down_s3_q <= 1'b0;
      up_s1_q <= 1'b0;
      up_s2_q <= 1'b0;
      up_s3_q <= 1'b0;
    end
    else
    begin
      down_s1_q <= gain_down_pin;
      down_s2_q <= down_s1_q;
      down_s3_q <= down_s2_q;
      up_s1_q <= gain_select_up_pin;
      up_s2_q <= up_s1_q;
      up_s3_q <= up_s2_q;
    end
  end

  // current attenuation: one value shared by both modes and the backoff
  always @*
  begin
    cur_d = cur_q;
    if (step_mode)
    begin
      if (!mode_prev_q)
        cur_d = start_q[`AOC_CODE_HI:0];
      else if (down_edge & ~up_edge)
        cur_d = aoc_sat_dec(cur_q);
      else if (up_edge & ~down_edge)
        cur_d = aoc_sat_add(cur_q, `AOC_ONE_CODE);
    end
    else if (mode_prev_q | (sel_val != sel_prev_q))
      cur_d = sel_val;
    // backoff wins over a pin step in the same cycle
    if (ovl_evt & (cur_q <= `AOC_MAX_CODE))
      cur_d = aoc_sat_add(cur_q, backoff_q[`AOC_STEP_HI:0]);
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_q <= `AOC_RST_CODE;
      sel_prev_q <= `AOC_RST_CODE;
      mode_prev_q <= 1'b0;
      atten_code_q <= `AOC_RST_CODE;
      atten_enable_q <= 1'b1;
    end
    else
    begin
      cur_q <= cur_d;
      sel_prev_q <= sel_val;
      mode_prev_q <= step_mode;
      atten_code_q <= cur_d;
      atten_enable_q <= (cur_d <= `AOC_MAX_CODE);
    end
  end

  // overload detector over eight-sample groups and reset pulse
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      grp_idx_q <= 3'h0;
      fs_cnt_q <= 4'h0;
      pulse_cnt_q <= `AOC_CNT_ZERO;
      converter_reset_q <= 1'b0;
    end
    else
    begin
      if (sample_valid)
      begin
        grp_idx_q <= grp_idx_q + 3'h1;
        if (grp_idx_q == `AOC_GRP_LAST)
          fs_cnt_q <= 4'h0;
        else
          fs_cnt_q <= fs_total;
      end
      if (ovl_evt)
      begin
        converter_reset_q <= 1'b1;
        pulse_cnt_q <= {plen_q[`AOC_PLEN_HI:0], `AOC_PULSE_LSBS};
      end
      else if (converter_reset_q)
      begin
        if (pulse_cnt_q == `AOC_CNT_ZERO)
          converter_reset_q <= 1'b0;
        else
          pulse_cnt_q <= pulse_cnt_q - 8'h01;
      end
    end
  end

endmodule // aoc_top

`default_nettype wire

/* File: tb/aoc_checker.sv */
// aoc_checker: port assertions for aoc_top
// assumes: bound from the bench top, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module aoc_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout_q,
  // converter and attenuator
  input wire logic sample_valid,
  input wire logic [4:0] atten_code_q,
  input wire logic atten_enable_q,
  input wire logic converter_reset_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic [8:0] hi_cnt_q;
  wire take = hsel && hready && htrans[1];
  // pulse length counter, too long for a repetition
  always @(posedge mclk or negedge nrst)
    if (!nrst)
      hi_cnt_q <= 9'h000;
    else
      hi_cnt_q <= converter_reset_q ? hi_cnt_q + 9'h001 : 9'h000;
  sequence s_rd_wait;
    !hreadyout_q ##1 hreadyout_q;
  endsequence
  sequence s_min_pulse;
    converter_reset_q [*8];
  endsequence
  a_read_wait: assert property (take && !hwrite |=> s_rd_wait)
    else $error("read not answered after one wait");
  a_write_fast: assert property (take && hwrite |=> hreadyout_q)
    else $error("write stalled");
  a_off_codes: assert property (atten_enable_q == (atten_code_q <= 5'h1B))
    else $error("enable disagrees with code");
  a_event_cause: assert property ($rose(converter_reset_q) |-> $past(sample_valid))
    else $error("reset pulse without a sample");
  a_pulse_min: assert property ($rose(converter_reset_q) |-> s_min_pulse)
    else $error("reset pulse under eight cycles");
  a_pulse_step: assert property ($fell(converter_reset_q) |-> hi_cnt_q[2:0] == 3'h0)
    else $error("reset pulse not a multiple of eight");
  a_pulse_max: assert property (hi_cnt_q <= 9'h100)
    else $error("reset pulse too long");
  a_backoff_clip: assert property ($rose(converter_reset_q)
    && $past(atten_code_q) < 5'h1C
    |-> atten_code_q >= $past(atten_code_q) && atten_code_q <= 5'h1B)
    else $error("backoff wrong or above 27");
endmodule // aoc_checker
`default_nettype wire

/* File: tb/aoc_gain_drv.sv */
// aoc_gain_drv: outside gain control party on the two pins
// assumes: pins pass a two-flop sync inside the block
`timescale 1ns/1ps
`default_nettype none
module aoc_gain_drv (
  // clock
  input wire logic mclk,
  // pins
  output logic gain_down_pin,
  output logic gain_select_up_pin
);
  initial
  begin
    gain_down_pin = 1'h0;
    gain_select_up_pin = 1'h0;
  end
  // level for select mode
  task automatic set_sel(input logic v);
    @(posedge mclk);
    gain_select_up_pin <= v;
  endtask
  // hold of 3 or more keeps edges apart for the sync
  task automatic step(input logic up, input int hold);
    @(posedge mclk);
    if (up)
      gain_select_up_pin <= 1'h1;
    else
      gain_down_pin <= 1'h1;
    repeat (hold) @(posedge mclk);
    gain_select_up_pin <= 1'h0;
    gain_down_pin <= 1'h0;
    repeat (hold) @(posedge mclk);
  endtask
endmodule // aoc_gain_drv
`default_nettype wire

/* File: tb/aoc_top_tb.sv */
// aoc_top_tb: register, pin and overload tests
// assumes: aoc_top, aoc_checker and aoc_gain_drv compiled
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module aoc_top_tb;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic sample_valid = 1'h0;
  logic [4:0] sample_data = 5'h00;
  logic [31:0] rdat;
  int err_count = 0;
  int samples_checked = 0;
  wire [31:0] hrdata_q;
  wire [4:0] atten_code_q;
  wire hreadyout_q, hresp_q, atten_enable_q, converter_reset_q, irq_q;
  wire gain_down_pin, gain_select_up_pin;
  always #2.5 mclk = ~mclk;
  aoc_top i_dut (.mclk, .nrst, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout_q), .hrdata_q, .hreadyout_q, .hresp_q, .gain_down_pin,
    .gain_select_up_pin, .sample_valid, .sample_data, .atten_code_q, .atten_enable_q,
    .converter_reset_q, .irq_q);
  aoc_gain_drv i_gain (.mclk, .gain_down_pin, .gain_select_up_pin);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // edge where hready is sampled high, bounded
  task automatic wait_hi();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout_q !== 1'h1 && n < 40);
    if (n >= 40)
    begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
    haddr <= {20'h00000, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    wait_hi();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_hi();
    rdat = hrdata_q;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'h1, idx, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    xfer(1'h0, idx, 8'h00);
    `CHK(rdat, {24'h000000, e})
  endtask
  // eight samples, the first nfs at full scale
  task automatic burst(input int nfs);
    for (int i = 0; i < 8; i++)
    begin
      sample_valid <= 1'h1;
      sample_data <= (i >= nfs) ? 5'h03 : (i % 2) ? 5'h18 : 5'h08;
      @(posedge mclk);
    end
    sample_valid <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic pulse(input logic [8:0] exp);
    int n;
    logic [8:0] w;
    n = 0;
    w = 9'h000;
    while (converter_reset_q !== 1'h1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    while (converter_reset_q === 1'h1 && w < 9'h120)
    begin
      @(posedge mclk);
      w++;
    end
    `CHK(w, exp)
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    rd(10'h180, 8'h00);
    rd(10'h181, 8'h0C);
    rd(10'h182, 8'h0C);
    rd(10'h183, 8'h00);
    rd(10'h184, 8'h0C);
    rd(10'h188, 8'h05);
    rd(10'h189, 8'h01);
    rd(10'h18A, 8'h06);
    rd(10'h18F, 8'h00);
    rd(10'h185, 8'h00);
    wr(10'h184, 8'hFF);
    rd(10'h184, 8'h6C);
    wr(10'h184, 8'h00);
    $display("test reset values done");
    wr(10'h181, 8'h03);
    wr(10'h182, 8'h14);
    `CHK(atten_code_q, 5'h03)
    i_gain.set_sel(1'h1);
    repeat (6) @(posedge mclk);
    rd(10'h184, 8'h94);
    wr(10'h182, 8'h1E);
    repeat (3) @(posedge mclk);
    `CHK(atten_enable_q, 1'h0)
    i_gain.set_sel(1'h0);
    repeat (6) @(posedge mclk);
    `CHK(atten_enable_q, 1'h1)
    `CHK(atten_code_q, 5'h03)
    $display("test level select done");
    wr(10'h183, 8'h1A);
    wr(10'h18D, 8'h02);
    wr(10'h180, 8'h01);
    repeat (2) @(posedge mclk);
    `CHK(atten_code_q, 5'h1A)
    i_gain.step(1'h1, 3);
    `CHK(irq_q, 1'h1)
    i_gain.step(1'h1, 4);
    `CHK(atten_code_q, 5'h1B)
    wr(10'h18C, 8'h02);
    wr(10'h18D, 8'h00);
    i_gain.step(1'h0, 3);
    `CHK(irq_q, 1'h0)
    rd(10'h184, 8'h1A);
    rd(10'h18C, 8'h02);
    wr(10'h183, 8'h00);
    wr(10'h180, 8'h00);
    wr(10'h180, 8'h01);
    i_gain.step(1'h0, 3);
    `CHK(atten_code_q, 5'h00)
    $display("test step mode done");
    wr(10'h18D, 8'h01);
    burst(5);
    repeat (2) @(posedge mclk);
    `CHK(converter_reset_q, 1'h0)
    burst(6);
    pulse(9'h010);
    `CHK(atten_code_q, 5'h06)
    `CHK(irq_q, 1'h1)
    wr(10'h18F, 8'h00);
    rd(10'h18F, 8'h01);
    wr(10'h18F, 8'h02);
    rd(10'h18F, 8'h00);
    `CHK(hresp_q, 1'h0)
    wr(10'h188, 8'h07);
    wr(10'h189, 8'h00);
    wr(10'h18A, 8'h1B);
    burst(8);
    pulse(9'h008);
    `CHK(atten_code_q, 5'h1B)
    wr(10'h18C, 8'h03);
    // the clear and the irq drop both land on the edge the write returns at, checked one edge later
    @(posedge mclk);
    `CHK(irq_q, 1'h0)
    $display("test overload done");
    end_of_test();
  end
endmodule // aoc_top_tb
bind aoc_top aoc_checker i_chk (.mclk, .nrst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout_q, .sample_valid, .atten_code_q, .atten_enable_q, .converter_reset_q);
`default_nettype wire
